// [rtl/fbws_host.sv]
// Host controller that drives a bus-paced flash part through its pins.
// Assumes software on a plain strobe port and a flash with no clock.
//
// Notes on behaviour
// - Program: write 40H, then data, same address.
// - Next byte only after previous op completes.
// - Full status check per byte or per series.
// - FFH returns device to array read mode.
// - Clear status before retrying after any error.
// - Lock: 60H then 01H block or F1H master.
// - Ready bit 7; ignore other bits while busy.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fbws_host
   import fbws_pkg::*;
#(
   parameter int AW = 21, // Flash byte address width.
   parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50 // Clear-status command code.
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic [AW-1:0] flashAddr,
   input wire logic [7:0] flashDqIn,
   output logic [7:0] flashDqOut,
   output logic flashDqOe,
   output logic flashCeN,
   output logic flashWeN,
   output logic flashOeN,
   output logic resetPowerdownPinN
);
   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------
   fbws_state_t state_r, state_nxt; // Sequencer state.
   logic [7:0] ph_r, ph_nxt; // Phase counter within one bus cycle.
   logic [2:0] op_r, op_nxt; // Operation in progress.
   logic [AW-1:0] addr_r, addr_nxt; // Target address.
   logic [7:0] data_r, data_nxt; // Byte to program.
   logic [7:0] devStatus_r, devStatus_nxt; // Last ready status read.
   logic [7:0] rdData_r, rdData_nxt; // Last array byte read.
   logic errSeen_r, errSeen_nxt; // Error seen since last clear.
   logic refused_r, refused_nxt; // Last command was refused.
   logic pinLevel_r, pinLevel_nxt; // Reset/power-down pin level.
   logic weN_r, weN_nxt;
   logic oeN_r, oeN_nxt;
   logic ceN_r, ceN_nxt;
   logic dqOe_r, dqOe_nxt;
   logic [7:0] dqOut_r, dqOut_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [7:0] dqMeta_r, dqSync_r; // Input synchroniser.
   logic ctrlWr; // Software writes the control register.
   logic inWrite, inRead; // Write or read bus cycle under way.
   logic wrDone, rdSample; // End of write cycle, read sample point.
   logic [7:0] wrByte; // Byte driven in the current write cycle.
   logic anyErr; // Error bit in the sampled status.

   assign ctrlWr = regWr && (regAddr == REG_CTRL);
   assign inWrite = (state_r == ST_WRA) || (state_r == ST_WRB);
   assign inRead = (state_r == ST_POLL) || (state_r == ST_RDA);
   assign wrDone = inWrite && (ph_r == 8'(WE_LOW_CYC + WE_HIGH_CYC - 1));
   assign rdSample = inRead && (ph_r == 8'(RD_CYC));
   // Errors counted include the sequence error pair and the supply flag.
   assign anyErr = dqSync_r[SR_ERASE_BIT] | dqSync_r[SR_PROG_BIT] | dqSync_r[SR_SUPPLY_BIT]
      | dqSync_r[SR_PROTECT_BIT];

   // ------------------------------------------------------------
   // Byte selection for each write cycle.
   // ------------------------------------------------------------
   // The first write carries the setup or one-cycle command code; the
   // second carries the data or the lock confirm code.
   always_comb begin
      wrByte = CMD_READ_ARRAY;
      if (state_r == ST_WRA) begin
         case (op_r)
            OP_PROG: wrByte = CMD_PROG_SETUP;
            OP_LOCKB, OP_LOCKM: wrByte = CMD_LOCK_SETUP;
            OP_CLEAR: wrByte = CMD_CLEAR_STATUS;
            default: wrByte = CMD_READ_ARRAY;
         endcase
      end else begin
         case (op_r)
            OP_PROG: wrByte = data_r;
            OP_LOCKB: wrByte = CMD_LOCK_BLOCK;
            default: wrByte = CMD_LOCK_MASTER;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------
   // Pin outputs follow the registered state by one cycle; data and the
   // strobe change on the same edge, and the address is set while idle.
   always_comb begin
      state_nxt = state_r;
      ph_nxt = ph_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      devStatus_nxt = devStatus_r;
      rdData_nxt = rdData_r;
      errSeen_nxt = errSeen_r;
      refused_nxt = refused_r;
      pinLevel_nxt = pinLevel_r;
      weN_nxt = !(inWrite && (ph_r < 8'(WE_LOW_CYC)));
      oeN_nxt = !(inRead && (ph_r < 8'(RD_CYC)));
      ceN_nxt = (state_r == ST_IDLE);
      dqOe_nxt = inWrite;
      dqOut_nxt = inWrite ? wrByte : dqOut_r;
      // Address and data are frozen while a sequence runs, so both writes
      // of a pair always land on the same location.
      if (regWr && (regAddr == REG_ADDR) && (state_r == ST_IDLE)) begin
         addr_nxt = regWdata[AW-1:0];
      end
      if (regWr && (regAddr == REG_DATA) && (state_r == ST_IDLE)) begin
         data_nxt = regWdata[7:0];
      end
      if (regWr && (regAddr == REG_CFG)) begin
         pinLevel_nxt = regWdata[0];
      end
      case (state_r)
         ST_IDLE: begin
            ph_nxt = 8'h00;
            // Commands are taken only here, so a new byte never starts
            // before the previous one has reported ready.
            if (ctrlWr) begin
               if (errSeen_r && ((regWdata[2:0] == OP_PROG) || (regWdata[2:0] == OP_LOCKB)
                  || (regWdata[2:0] == OP_LOCKM))) begin
                  refused_nxt = 1'b1;
               end else if (regWdata[2:0] >= OP_PROG && regWdata[2:0] <= OP_READ) begin
                  refused_nxt = 1'b0;
                  op_nxt = regWdata[2:0];
                  state_nxt = ST_WRA;
               end else begin
                  refused_nxt = 1'b1;
               end
            end
         end
         ST_WRA: begin
            ph_nxt = ph_r + 8'h01;
            if (wrDone) begin
               ph_nxt = 8'h00;
               case (op_r)
                  OP_PROG, OP_LOCKB, OP_LOCKM: state_nxt = ST_WRB;
                  OP_READ: state_nxt = ST_RDA;
                  OP_CLEAR: begin
                     errSeen_nxt = 1'b0;
                     state_nxt = ST_IDLE;
                  end
                  default: state_nxt = ST_IDLE;
               endcase
            end
         end
         ST_WRB: begin
            ph_nxt = ph_r + 8'h01;
            if (wrDone) begin
               ph_nxt = 8'h00;
               state_nxt = ST_POLL;
            end
         end
         ST_POLL: begin
            ph_nxt = ph_r + 8'h01;
            if (rdSample) begin
               ph_nxt = 8'h00;
               // Other bits are meaningless until ready, so keep reading.
               if (dqSync_r[SR_READY_BIT]) begin
                  devStatus_nxt = dqSync_r;
                  // Accumulate so a series may be checked once at its end.
                  errSeen_nxt = errSeen_r | anyErr;
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_RDA: begin
            ph_nxt = ph_r + 8'h01;
            if (rdSample) begin
               rdData_nxt = dqSync_r;
               ph_nxt = 8'h00;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            ph_nxt = 8'h00;
         end
      endcase
      // Read data answer, presented in the cycle after the strobe.
      rdata_nxt = 32'h0000_0000;
      if (regRd) begin
         case (regAddr)
            REG_CTRL: rdata_nxt = {29'h0000_0000, op_r};
            REG_ADDR: rdata_nxt = 32'(addr_r);
            REG_DATA: rdata_nxt = {24'h00_0000, data_r};
            REG_STATUS: rdata_nxt = {21'h00_0000, refused_r, errSeen_r,
               (state_r != ST_IDLE), devStatus_r};
            REG_RDATA: rdata_nxt = {24'h00_0000, rdData_r};
            REG_CFG: rdata_nxt = {31'h0000_0000, pinLevel_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      dqMeta_r <= flashDqIn;
      dqSync_r <= dqMeta_r;
      if (!reset_n) begin
         state_r <= ST_IDLE;
         ph_r <= 8'h00;
         op_r <= 3'h0;
         addr_r <= '0;
         data_r <= 8'h00;
         devStatus_r <= 8'h00;
         rdData_r <= 8'h00;
         errSeen_r <= 1'b0;
         refused_r <= 1'b0;
         pinLevel_r <= CFG_RST;
         weN_r <= 1'b1;
         oeN_r <= 1'b1;
         ceN_r <= 1'b1;
         dqOe_r <= 1'b0;
         dqOut_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         ph_r <= ph_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         devStatus_r <= devStatus_nxt;
         rdData_r <= rdData_nxt;
         errSeen_r <= errSeen_nxt;
         refused_r <= refused_nxt;
         pinLevel_r <= pinLevel_nxt;
         weN_r <= weN_nxt;
         oeN_r <= oeN_nxt;
         ceN_r <= ceN_nxt;
         dqOe_r <= dqOe_nxt;
         dqOut_r <= dqOut_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign flashAddr = addr_r;
   assign flashDqOut = dqOut_r;
   assign flashDqOe = dqOe_r;
   assign flashCeN = ceN_r;
   assign flashWeN = weN_r;
   assign flashOeN = oeN_r;
   assign resetPowerdownPinN = pinLevel_r;

   // ------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   prog_setup_a: assert property ((state_r == ST_WRB) && ($past(state_r) == ST_WRA)
      && (op_r == OP_PROG) |-> $past(flashDqOut) == CMD_PROG_SETUP)
      else $error("Program data write not preceded by setup code.");
   same_addr_a: assert property ((state_r == ST_WRB) |-> $stable(flashAddr))
      else $error("Address moved between setup and data write.");
   poll_hold_a: assert property ((state_r == ST_POLL) |=> (state_r == ST_POLL)
      || (state_r == ST_IDLE))
      else $error("New operation started before ready.");
   ready_only_a: assert property ((devStatus_r != $past(devStatus_r))
      |-> $past(dqSync_r[SR_READY_BIT]) && ($past(state_r) == ST_POLL))
      else $error("Status taken while device busy.");
   err_accum_a: assert property ((state_r == ST_POLL) && rdSample && dqSync_r[SR_READY_BIT]
      && anyErr |=> errSeen_r ##1 errSeen_r || (state_r != ST_IDLE))
      else $error("Error flag not accumulated.");
   refuse_err_a: assert property ((state_r == ST_IDLE) && errSeen_r && ctrlWr
      && (regWdata[2:0] == OP_PROG) |=> (state_r == ST_IDLE) && refused_r)
      else $error("Program accepted with uncleared error.");
   lock_master_a: assert property ((state_r == ST_WRB) && !flashWeN && (op_r == OP_LOCKM)
      |-> flashDqOut == CMD_LOCK_MASTER)
      else $error("Master lock confirm code wrong.");
   array_mode_a: assert property ((state_r == ST_RDA) && ($past(state_r) == ST_WRA)
      |-> $past(flashDqOut) == CMD_READ_ARRAY)
      else $error("Array read without read-array command.");
endmodule : fbws_host
`default_nettype wire

// [rtl/fbws_pkg.sv]
// Constants shared by the flash byte-write and lock sequencer host.
// Assumes a 200 MHz core clock and a flash part paced only by bus cycles.
package fbws_pkg;
   // ------------------------------------------------------------
   // Timing: figures in ns, cycle counts derived from the clock.
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5; // Core clock period.
   localparam int WE_LOW_NS = 50; // Least write strobe low time.
   localparam int WE_HIGH_NS = 30; // Least write strobe high time.
   localparam int RD_ACC_NS = 100; // Least read access time.
   localparam int SYNC_CYC = 2; // Two-flop input synchroniser latency.
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC = RD_ACC_CYC + SYNC_CYC + 1; // Sample point.
   // ------------------------------------------------------------
   // Flash command codes.
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
   localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   // ------------------------------------------------------------
   // Device status bit positions.
   // ------------------------------------------------------------
   localparam int SR_READY_BIT = 7;
   localparam int SR_ERASE_BIT = 5;
   localparam int SR_PROG_BIT = 4;
   localparam int SR_SUPPLY_BIT = 3;
   localparam int SR_PROTECT_BIT = 1;
   // ------------------------------------------------------------
   // Software register map and reset values.
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_CFG = 8'h14;
   localparam logic CFG_RST = 1'b1; // Reset/power-down pin released.
   // Operation codes written to the control register.
   localparam logic [2:0] OP_PROG = 3'h1;
   localparam logic [2:0] OP_LOCKB = 3'h2;
   localparam logic [2:0] OP_LOCKM = 3'h3;
   localparam logic [2:0] OP_CLEAR = 3'h4;
   localparam logic [2:0] OP_ARRAY = 3'h5;
   localparam logic [2:0] OP_READ = 3'h6;
   // Sequencer states, one-hot.
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_WRA = 5'h02,
      ST_WRB = 5'h04,
      ST_POLL = 5'h08,
      ST_RDA = 5'h10
   } fbws_state_t;
endpackage : fbws_pkg

// [tb/fbws_flash_model.sv]
// Behavioural model of the bus-paced flash part seen by the sequencer host.
// Assumes commands latch on the rising write strobe while chip enable is low.
`timescale 1ns/100ps
`default_nettype none
module fbws_flash_model #(
   parameter int AW = 21
) (
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] dqHost,
   input wire logic dqOe,
   input wire logic ceN,
   input wire logic weN,
   input wire logic oeN,
   input wire logic pinRstN,
   input wire logic failNext,
   input wire logic slow,
   output logic [7:0] dqOut
);
   // ------------------------------------------------------------
   // Device state.
   // ------------------------------------------------------------
   logic [7:0] mem [256]; // Array, erased to all ones.
   logic [3:0] lockBit; // One lock bit per 64-byte block of the model.
   logic masterLock; // Master lock bit.
   logic [7:0] errBits; // Sticky error flags in their status positions.
   logic ready; // Internal sequencer idle.
   logic statusMode; // Reads return status rather than the array.
   logic [1:0] pend; // Setup seen: 1 program, 2 lock.
   logic [AW-1:0] setupAddr; // Address of the program setup write.
   logic [7:0] cur; // Value the part would drive.
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      lockBit = 4'h0;
      masterLock = 1'b0;
      errBits = 8'h00;
      ready = 1'b1;
      statusMode = 1'b0;
      pend = 2'd0;
   end
   // ------------------------------------------------------------
   // Command decode on the rising write strobe.
   // ------------------------------------------------------------
   always @(posedge weN) begin
      if (!ceN && dqOe && pinRstN) begin
         if (pend == 2'd1) begin
            pend = 2'd0;
            statusMode = 1'b1;
            if (addr != setupAddr) begin
               errBits = errBits | 8'h30;
            end else if (lockBit[addr[7:6]]) begin
               errBits = errBits | 8'h12;
            end else if (failNext) begin
               errBits = errBits | 8'h10;
            end else begin
               mem[addr[7:0]] = mem[addr[7:0]] & dqHost;
            end
            ready = 1'b0;
            ready <= #(slow ? 2000 : 60) 1'b1;
         end else if (pend == 2'd2) begin
            pend = 2'd0;
            statusMode = 1'b1;
            if (dqHost == 8'h01) begin
               lockBit[addr[7:6]] = 1'b1;
            end else if (dqHost == 8'hF1) begin
               masterLock = 1'b1;
            end else begin
               errBits = errBits | 8'h30;
            end
            ready = 1'b0;
            ready <= #(slow ? 2000 : 60) 1'b1;
         end else begin
            case (dqHost)
               8'h40: begin
                  pend = 2'd1;
                  setupAddr = addr;
               end
               8'h60: pend = 2'd2;
               8'h50: errBits = 8'h00;
               8'hFF: statusMode = 1'b0;
               default: statusMode = 1'b1;
            endcase
         end
      end
   end
   // A low reset pin drops any half-entered sequence.
   always @(negedge pinRstN) begin
      statusMode = 1'b0;
      pend = 2'd0;
   end
   // While busy only bit 7 is meaningful, so the low bits carry junk.
   always_comb begin
      cur = statusMode ? (ready ? (8'h80 | errBits) : 8'h2A) : mem[addr[7:0]];
   end
   // Released pins show the inverse, so a stale value never passes as data.
   assign dqOut = (!ceN && !oeN) ? cur : ~cur;
endmodule : fbws_flash_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the flash sequencer host on its register port.
// Assumes the flash model in fbws_flash_model.sv stands on the pins.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import fbws_pkg::*;
   logic core_clk = 1'b0; // 200 MHz clock.
   logic reset_n = 1'b0; // Synchronous reset, active low.
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic [20:0] flashAddr;
   logic [7:0] flashDqIn;
   logic [7:0] flashDqOut;
   logic flashDqOe, flashCeN, flashWeN, flashOeN, pinRstN;
   logic failNext = 1'b0; // Makes the next program fail to store.
   logic slow = 1'b0; // Selects the long busy time.
   int mismatches = 0;
   int testsRun = 0;
   int cycles = 0;
   logic [31:0] st;
   always #2.5 core_clk = ~core_clk;
   fbws_host #(.AW(21)) fbws_host_inst (.core_clk(core_clk), .reset_n(reset_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .flashAddr(flashAddr), .flashDqIn(flashDqIn),
      .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCeN(flashCeN),
      .flashWeN(flashWeN), .flashOeN(flashOeN), .resetPowerdownPinN(pinRstN));
   fbws_flash_model #(.AW(21)) fbws_flash_model_inst (.addr(flashAddr),
      .dqHost(flashDqOut), .dqOe(flashDqOe), .ceN(flashCeN), .weN(flashWeN),
      .oeN(flashOeN), .pinRstN(pinRstN), .failNext(failNext), .slow(slow),
      .dqOut(flashDqIn));
   // ------------------------------------------------------------
   // Access and reporting tasks.
   // ------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done
   // A gap cycle follows each write, so strobes never get two drivers at once.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
      @(posedge core_clk);
   endtask : rd
   // Polls the busy bit under a bounded count; leaves the status in st.
   task automatic waitIdle();
      int n;
      n = 0;
      rd(REG_STATUS, st);
      while (st[8] !== 1'b0 && n < 4000) begin
         rd(REG_STATUS, st);
         n++;
      end
      // A hang counts as a mismatch and goes straight to the verdict.
      if (st[8] !== 1'b0) begin
         mismatches++;
         $display("Error busy expected 0 seen 1");
         summarize();
      end
   endtask : waitIdle
   task automatic op(input logic [2:0] o, input logic [31:0] a, input logic [31:0] d,
                     input logic w);
      wr(REG_ADDR, a);
      wr(REG_DATA, d);
      wr(REG_CTRL, {29'h0, o});
      if (w) begin
         waitIdle();
      end
   endtask : op
   // The ceiling is far above the thousand or so cycles the tests need.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // Test sequence.
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      rd(REG_STATUS, st);
      chk("status reset", 32'h0, st);
      rd(REG_CFG, st);
      chk("cfg reset", 32'h1, st);
      rd(8'h20, st);
      chk("unmapped", 32'h0, st);
      done("reset");
      slow <= 1'b1;
      op(OP_PROG, 32'h12, 32'h5A, 1'b1);
      chk("prog status", 32'h80, st);
      slow <= 1'b0;
      op(OP_PROG, 32'h20, 32'h33, 1'b0);
      wr(REG_ADDR, 32'h99);
      chk("addr hold", 32'h20, {11'h0, flashAddr});
      waitIdle();
      chk("prog2 status", 32'h80, st);
      op(OP_READ, 32'h12, 32'h0, 1'b1);
      rd(REG_RDATA, st);
      chk("array byte", 32'h5A, st);
      done("program");
      op(OP_LOCKB, 32'h40, 32'h0, 1'b1);
      chk("lock status", 32'h80, st);
      op(OP_PROG, 32'h41, 32'h77, 1'b1);
      chk("protect status", 32'h292, st);
      op(OP_PROG, 32'h42, 32'h77, 1'b1);
      chk("refused status", 32'h692, st);
      op(OP_CLEAR, 32'h0, 32'h0, 1'b1);
      chk("cleared flags", 32'h0, st & 32'h600);
      op(OP_PROG, 32'h05, 32'hA0, 1'b1);
      chk("after clear", 32'h80, st);
      done("lock");
      failNext <= 1'b1;
      op(OP_PROG, 32'h06, 32'h00, 1'b1);
      chk("fail status", 32'h290, st);
      failNext <= 1'b0;
      op(OP_READ, 32'h06, 32'h0, 1'b1);
      chk("sticky flag", 32'h200, st & 32'h200);
      rd(REG_RDATA, st);
      chk("unstored byte", 32'hFF, st);
      op(OP_CLEAR, 32'h0, 32'h0, 1'b1);
      op(OP_LOCKM, 32'h0, 32'h0, 1'b1);
      chk("master status", 32'h80, st);
      // An unknown operation code is refused and leaves the last op in place.
      wr(REG_CTRL, 32'h7);
      rd(REG_STATUS, st);
      chk("bad op", 32'h400, st & 32'h500);
      rd(REG_CTRL, st);
      chk("ctrl op", 32'h3, st);
      // The array-mode command alone must put the part back in array reads.
      op(OP_ARRAY, 32'h0, 32'h0, 1'b1);
      chk("refused cleared", 32'h0, st & 32'h400);
      chk("array mode", 32'h0, {31'h0, fbws_flash_model_inst.statusMode});
      done("error");
      wr(REG_CFG, 32'h0);
      @(posedge core_clk);
      chk("pin low", 32'h0, {31'h0, pinRstN});
      wr(REG_CFG, 32'h1);
      @(posedge core_clk);
      chk("pin high", 32'h1, {31'h0, pinRstN});
      done("pin");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
